// [rtl/ipv_top.sv]
// Purpose: Interrupt priority and vectoring with an APB register file.
// Assumes: Request flags are levels held by their peripherals until cleared.
// Notes:   The core pulses irq_ack when it enters a vector and irq_ret on return.
`timescale 1ns/1ns
module ipv_top (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic [9:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [14:0] irq_req,
   input  wire logic        irq_ack,
   input  wire logic        irq_ret,
   output logic             irq_valid,
   output logic      [15:0] irq_vector,
   output logic      [1:0]  irq_level,
   output logic      [3:0]  irq_active
);
   logic [7:0]  en_one;
   logic [7:0]  en_two;
   logic [7:0]  one_low;
   logic [7:0]  one_high;
   logic [7:0]  two_low;
   logic [7:0]  two_high;
   logic [3:0]  in_service;
   logic [7:0]  next_en_one;
   logic [7:0]  next_en_two;
   logic [7:0]  next_one_low;
   logic [7:0]  next_one_high;
   logic [7:0]  next_two_low;
   logic [7:0]  next_two_high;
   logic [3:0]  next_in_service;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        next_irq_valid;
   logic [15:0] next_irq_vector;
   logic [1:0]  next_irq_level;
   logic [14:0] src_en;
   logic [14:0] src_hi;
   logic [14:0] src_lo;
   logic [7:0]  idx;
   logic        hit;
   logic        wr_go;
   logic        act_valid;
   logic [1:0]  act_level;

   ipv_arb_if arb_bus ();

   ipv_arbiter u_arb (
      .a (arb_bus.arb)
   );

   // Per-slot enable and priority bits from the register groups.
   for (genvar s = 0; s < ipv_pkg::NUM_SRC; s++) begin : g_slot
      localparam logic [3:0] SB = ipv_pkg::slot_bit(4'(s));
      assign src_en[s] = SB[3] ? en_two[SB[2:0]] : en_one[SB[2:0]];
      assign src_lo[s] = SB[3] ? two_low[SB[2:0]] : one_low[SB[2:0]];
      assign src_hi[s] = SB[3] ? two_high[SB[2:0]] : one_high[SB[2:0]];
      assign arb_bus.levels[2*s +: 2] = {src_hi[s], src_lo[s]};
   end

   assign arb_bus.pending = irq_req & src_en & {15{en_one[ipv_pkg::GATE_BIT]}};

   // Level of the service in progress is the highest in-service bit.
   always_comb begin
      act_valid = |in_service;
      act_level = 2'b00;
      for (int l = 0; l < 4; l++) begin
         if (in_service[l]) begin
            act_level = 2'(l);
         end
      end
   end

   assign idx   = paddr[9:2];
   assign hit   = idx == ipv_pkg::IDX_EN_ONE || idx == ipv_pkg::IDX_EN_TWO
               || idx == ipv_pkg::IDX_ONE_LOW || idx == ipv_pkg::IDX_ONE_HIGH
               || idx == ipv_pkg::IDX_TWO_LOW || idx == ipv_pkg::IDX_TWO_HIGH
               || idx == ipv_pkg::IDX_STATUS;
   assign wr_go = psel && penable && pready && pwrite && pstrb[0] && hit;

   // Register file and bus answer.
   always_comb begin
      next_en_one   = en_one;
      next_en_two   = en_two;
      next_one_low  = one_low;
      next_one_high = one_high;
      next_two_low  = two_low;
      next_two_high = two_high;
      next_pready   = psel && penable && !pready;
      next_pslverr  = psel && penable && !pready && !hit;
      next_prdata   = 32'h0000_0000;
      if (wr_go) begin
         unique case (idx)
            ipv_pkg::IDX_EN_ONE:   next_en_one = pwdata[7:0];
            ipv_pkg::IDX_EN_TWO:   next_en_two = pwdata[7:0];
            ipv_pkg::IDX_ONE_LOW:  next_one_low = pwdata[7:0] & ipv_pkg::MASK_ONE;
            ipv_pkg::IDX_ONE_HIGH: next_one_high = pwdata[7:0] & ipv_pkg::MASK_ONE;
            ipv_pkg::IDX_TWO_LOW:  next_two_low = pwdata[7:0] & ipv_pkg::MASK_TWO;
            ipv_pkg::IDX_TWO_HIGH: next_two_high = pwdata[7:0] & ipv_pkg::MASK_TWO;
            default:               next_en_one = en_one;
         endcase
      end
      if (psel && penable && !pready && !pwrite) begin
         if (idx == ipv_pkg::IDX_EN_ONE) next_prdata[7:0] = en_one;
         if (idx == ipv_pkg::IDX_EN_TWO) next_prdata[7:0] = en_two;
         if (idx == ipv_pkg::IDX_ONE_LOW) next_prdata[7:0] = one_low;
         if (idx == ipv_pkg::IDX_ONE_HIGH) next_prdata[7:0] = one_high;
         if (idx == ipv_pkg::IDX_TWO_LOW) next_prdata[7:0] = two_low;
         if (idx == ipv_pkg::IDX_TWO_HIGH) next_prdata[7:0] = two_high;
         if (idx == ipv_pkg::IDX_STATUS) begin
            next_prdata[15:0] = {arb_bus.win_valid, arb_bus.win_level, arb_bus.win_slot,
                                 4'b0000, irq_valid, in_service};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         en_one   <= ipv_pkg::RST_REG;
         en_two   <= ipv_pkg::RST_REG;
         one_low  <= ipv_pkg::RST_REG;
         one_high <= ipv_pkg::RST_REG;
         two_low  <= ipv_pkg::RST_REG;
         two_high <= ipv_pkg::RST_REG;
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         en_one   <= next_en_one;
         en_two   <= next_en_two;
         one_low  <= next_one_low;
         one_high <= next_one_high;
         two_low  <= next_two_low;
         two_high <= next_two_high;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
      end
   end

   // Request presentation and nesting of services.
   always_comb begin
      next_in_service = in_service;
      if (irq_ret) begin
         next_in_service[act_level] = 1'b0;
      end
      if (irq_ack && irq_valid) begin
         next_in_service[irq_level] = 1'b1;
      end
      next_irq_valid  = arb_bus.win_valid && !(irq_ack && irq_valid)
                     && (!act_valid || arb_bus.win_level > act_level);
      next_irq_vector = ipv_pkg::VEC_BASE
                     + 16'({arb_bus.win_slot, ipv_pkg::VEC_SHIFT'(0)});
      next_irq_level  = arb_bus.win_level;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         in_service <= 4'h0;
         irq_valid  <= 1'b0;
         irq_vector <= ipv_pkg::VEC_BASE;
         irq_level  <= 2'b00;
         irq_active <= 4'h0;
      end else begin
         in_service <= next_in_service;
         irq_valid  <= next_irq_valid;
         irq_vector <= next_irq_vector;
         irq_level  <= next_irq_level;
         irq_active <= next_in_service;
      end
   end
endmodule : ipv_top

// [include/ipv_pkg.sv]
// Purpose: Shared constants for the interrupt priority and vectoring block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Slot numbers follow the vector table order, slot 0 at the lowest vector.
package ipv_pkg;
   localparam int          NUM_SRC       = 15;
   localparam int          ADDR_W        = 10;
   // Register indices.
   localparam logic [7:0]  IDX_EN_ONE    = 8'ha8;
   localparam logic [7:0]  IDX_EN_TWO    = 8'he8;
   localparam logic [7:0]  IDX_ONE_HIGH  = 8'hb7;
   localparam logic [7:0]  IDX_ONE_LOW   = 8'hb8;
   localparam logic [7:0]  IDX_TWO_LOW   = 8'hf8;
   localparam logic [7:0]  IDX_TWO_HIGH  = 8'hf7;
   localparam logic [7:0]  IDX_STATUS    = 8'hc0;
   // Reset values and masks.
   localparam logic [7:0]  RST_REG       = 8'h00;
   localparam logic [7:0]  MASK_ONE      = 8'h7f;
   localparam logic [7:0]  MASK_TWO      = 8'hff;
   localparam int          GATE_BIT      = 7;
   // Vector generation.
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam int          VEC_SHIFT     = 3;
   // Fixed order within a level, highest first, as slot numbers.
   localparam logic [3:0]  PRIO_ORDER [0:14] = '{
      4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
      4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he};

   // Maps a slot to its register group (0 or 1) and bit position.
   function automatic logic [3:0] slot_bit(input logic [3:0] slot);
      logic [3:0] r;
      r = 4'h0;
      if (slot <= 4'h5) begin
         r = {1'b0, slot[2:0]};
      end else if (slot <= 4'h9) begin
         r = {1'b1, 3'(slot - 4'h6)};
      end else if (slot == 4'ha) begin
         r = 4'h6;
      end else begin
         r = {1'b1, 3'(slot - 4'h7)};
      end
      return r;
   endfunction : slot_bit
endpackage : ipv_pkg

// [include/ipv_arb_if.sv]
// Purpose: Carries requests and levels to the arbiter and the winner back.
// Assumes: Arbiter is purely combinational.
// Notes:   Level of slot s sits in levels[2*s+1:2*s].
`timescale 1ns/1ns
interface ipv_arb_if;
   logic [14:0] pending;
   logic [29:0] levels;
   logic        win_valid;
   logic [3:0]  win_slot;
   logic [1:0]  win_level;
   modport ctrl (output pending, output levels, input win_valid, input win_slot,
                 input win_level);
   modport arb  (input pending, input levels, output win_valid, output win_slot,
                 output win_level);
endinterface : ipv_arb_if

// [rtl/ipv_arbiter.sv]
// Purpose: Picks the winning pending source by level, then fixed order.
// Assumes: Pending already gated by enables.
// Notes:   Walks the order from last entry to first so the earlier entry wins ties.
`timescale 1ns/1ns
module ipv_arbiter (
   ipv_arb_if.arb a
);
   always_comb begin
      logic [3:0] s;
      logic [1:0] lv;
      s = 4'h0;
      lv = 2'b00;
      a.win_valid = 1'b0;
      a.win_slot = 4'h0;
      a.win_level = 2'b00;
      for (int i = ipv_pkg::NUM_SRC - 1; i >= 0; i--) begin
         s = ipv_pkg::PRIO_ORDER[i];
         lv = a.levels[2*s +: 2];
         if (a.pending[s] && (!a.win_valid || lv >= a.win_level)) begin
            a.win_valid = 1'b1;
            a.win_slot = s;
            a.win_level = lv;
         end
      end
   end
endmodule : ipv_arbiter

// [tb/ipv_chk.sv]
// Purpose: Port assertions for the priority and vectoring block.
// Assumes: One clock; reset disables every check.
// Notes:   Bound into the top module below.
`timescale 1ns/1ns
module ipv_chk (
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [14:0] irq_req,
   input wire logic        irq_ack,
   input wire logic        irq_ret,
   input wire logic        irq_valid,
   input wire logic [15:0] irq_vector,
   input wire logic [1:0]  irq_level,
   input wire logic [3:0]  irq_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_pulse; pready ##1 !pready; endsequence
   property p_ready; s_access |=> s_pulse; endproperty
   a_ready: assert property (p_ready) else $error("bad ready");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("bad error");
   property p_vec; irq_valid |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_idle; irq_req == 15'h0 |=> !irq_valid; endproperty
   a_idle: assert property (p_idle) else $error("valid without request");
   property p_refuse; irq_valid |-> (irq_active >> irq_level) == 4'h0; endproperty
   a_refuse: assert property (p_refuse) else $error("level not above service");
   property p_drop; irq_valid && irq_ack |=> !irq_valid; endproperty
   a_drop: assert property (p_drop) else $error("valid after ack");
   property p_take; irq_valid && irq_ack |=> irq_active[$past(irq_level)]; endproperty
   a_take: assert property (p_take) else $error("level not in service");
   property p_ret; irq_ret && !irq_ack && irq_active != 4'h0
      |=> $countones(irq_active) + 1 == $countones($past(irq_active)); endproperty
   a_ret: assert property (p_ret) else $error("return clears one level");
endmodule : ipv_chk
bind ipv_top ipv_chk u_ipv_chk (.mclk, .srst, .psel, .penable, .prdata, .pready, .pslverr,
   .irq_req, .irq_ack, .irq_ret, .irq_valid, .irq_vector, .irq_level, .irq_active);

// [tb/ipv_core_model.sv]
// Purpose: Core side that takes presented vectors and returns on command.
// Assumes: A vector is taken only while it is presented.
// Notes:   The slow setting waits three cycles before taking a vector.
`timescale 1ns/1ns
module ipv_core_model (
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic irq_valid,
   input  wire logic slow,
   input  wire logic ret_cmd,
   output logic      irq_ack,
   output logic      irq_ret
);
   logic [1:0] wait_cnt;
   always @(posedge mclk) begin
      irq_ret <= ret_cmd && !srst;
      irq_ack <= 1'b0;
      if (srst || !irq_valid || irq_ack) begin
         wait_cnt <= 2'h0;
      end else if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
         irq_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule : ipv_core_model

// [tb/tb_irq_priority_vectoring.sv]
// Purpose: Self-checking bench for the priority and vectoring block.
// Assumes: The core model takes vectors; the bench orders returns.
// Notes:   Winners come from own order and bit-position tables.
`timescale 1ns/1ns
module tb_irq_priority_vectoring;
   localparam logic [59:0] ORD = 60'h05a16b27c38d49e;
   localparam logic [59:0] MAP = 60'h01234589ab6cdef;
   localparam logic [47:0] IDX = {ipv_pkg::IDX_EN_ONE, ipv_pkg::IDX_EN_TWO,
      ipv_pkg::IDX_ONE_LOW, ipv_pkg::IDX_TWO_LOW, ipv_pkg::IDX_ONE_HIGH, ipv_pkg::IDX_TWO_HIGH};
   logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, ret_cmd = 0, slow = 0;
   logic [9:0]  paddr = '0, b;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0]  pstrb = 4'hf, irq_active;
   logic [14:0] irq_req = '0;
   logic [15:0] lo, hi, en, irq_vector;
   logic [17:0] v, e;
   logic [1:0]  irq_level;
   logic        pready, pslverr, irq_ack, irq_ret, irq_valid;
   logic [9:0]  q_bus[$];
   logic [17:0] q_vec[$];
   int          n_fail = 0, n_checks = 0, seed = 46;
   always #2 mclk = ~mclk;
   ipv_top u_ipv_top (.mclk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .irq_req, .irq_ack, .irq_ret, .irq_valid, .irq_vector,
      .irq_level, .irq_active);
   ipv_core_model u_ipv_core_model (.mclk, .srst, .irq_valid, .slow, .ret_cmd, .irq_ack,
      .irq_ret);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, d, e, input logic err);
      q_bus.push_back({w, err, e});
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {a, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask : bus
   task automatic ret;
      ret_cmd <= 1;
      @(posedge mclk);
      ret_cmd <= 0;
   endtask : ret
   task automatic setregs(input logic [14:0] r);
      logic [47:0] d;
      d = {1'b0, en[6:0], en[15:8], lo[7:0], lo[15:8], hi[7:0], hi[15:8]};
      for (int i = 0; i < 6; i++) bus(1, IDX[47-8*i -: 8], d[47-8*i -: 8], 8'h0, 0);
      irq_req <= r;
      repeat (4) @(posedge mclk);
      chk({15'h0, irq_valid}, 16'h0);
      bus(1, ipv_pkg::IDX_EN_ONE, en[7:0], 8'h0, 0);
   endtask : setregs
   // Expected result is the level in bits 17:16 and the vector below it.
   function automatic logic [17:0] pick(input logic [14:0] req);
      logic [3:0] s;
      logic [3:0] m;
      for (int lv = 3; lv >= 0; lv--) begin
         for (int i = 0; i < 15; i++) begin
            s = ORD[59-4*i -: 4];
            m = MAP[59-4*s -: 4];
            if (req[s] && en[m] && en[7] && {hi[m], lo[m]} == lv) begin
               return {2'(lv), 16'h0003 + 16'({s, 3'h0})};
            end
         end
      end
      return 18'h0;
   endfunction : pick
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1) begin
         b = q_bus.size() ? q_bus.pop_front() : 10'h3ff;
         chk({15'h0, pslverr}, {15'h0, b[8]});
         if (!b[9]) chk(prdata[15:0], {8'h0, b[7:0]});
      end
      if (irq_ack === 1'b1) begin
         e = q_vec.size() ? q_vec.pop_front() : 'x;
         chk(irq_vector, e[15:0]);
         chk({14'h0, irq_level}, {14'h0, e[17:16]});
      end
   end
   initial begin
      #200000;
      n_fail++;
      print_verdict;
   end
   initial begin
      repeat (5) @(posedge mclk);
      srst <= 0;
      for (int i = 0; i < 6; i++) bus(0, IDX[47-8*i -: 8], 8'h0, 8'h0, 0);
      for (int i = 0; i < 6; i++) bus(1, IDX[47-8*i -: 8], 8'hff, 8'h0, 0);
      for (int i = 0; i < 6; i++) begin
         bus(0, IDX[47-8*i -: 8], 8'h0, 8'(48'hffff7fff7fff >> (40-8*i)), 0);
      end
      bus(0, 8'h00, 8'h0, 8'h0, 1);
      // A write without the low byte strobe must leave the register alone.
      pstrb <= 4'he;
      bus(1, ipv_pkg::IDX_EN_TWO, 8'h00, 8'h0, 0);
      pstrb <= 4'hf;
      bus(0, ipv_pkg::IDX_EN_TWO, 8'h0, 8'hff, 0);
      for (int r = 0; r < 6; r++) begin
         lo = 16'($random(seed));
         hi = 16'($random(seed));
         en = 16'($random(seed)) | 16'h0080;
         slow <= r[0];
         setregs(15'($random(seed)));
         v = pick(irq_req);
         while (v != 18'h0) begin
            q_vec.push_back(v);
            @(posedge mclk iff irq_ack);
            irq_req[(v[15:0] - 16'h3) >> 3] <= 1'b0;
            @(posedge mclk);
            v = pick(irq_req);
            ret;
         end
      end
      lo = 16'h8001;
      hi = 16'h8000;
      en = 16'hffff;
      setregs(15'h0001);
      q_vec.push_back(18'h10003);
      @(posedge mclk iff irq_ack);
      irq_req <= 15'h4001;
      q_vec.push_back(18'h30073);
      @(posedge mclk iff irq_ack);
      irq_req <= 15'h0001;
      @(posedge mclk);
      chk({12'h0, irq_active}, 16'h000a);
      ret;
      repeat (6) @(posedge mclk);
      q_vec.push_back(18'h10003);
      ret;
      @(posedge mclk iff irq_ack);
      irq_req <= 15'h0;
      ret;
      repeat (6) @(posedge mclk);
      print_verdict;
   end
endmodule : tb_irq_priority_vectoring
